// *** core/spi_frame_pkg.sv ***
// Shared constants of the serial frame decoder and its master
// Operation
// - Write frame: address, then bytes, address increments
// - Write byte committed at its last falling edge
// - Partial write byte dropped on select rise
// - Writes to absent or read-only addresses ignored
// - Read frame: address in, bytes out, incrementing
// - Sample on falling edge, drive on rising
// - Absent register reads back as zero
// - Mode 10, code zero loads 1 to 96 bytes
// - Partial FIFO load byte is not stored
// - Mode 10, code all ones reads FIFO
// - Cut FIFO read byte stays unread
// - Direct command byte launched on last falling edge
// - Lasting command: master waits, device raises interrupt
// - Immediate command may chain without select rise
// - Select high holds the port in reset
// - First two bits choose the operation, MSB first
// - Data-out tristated unless shifting read data
// - FIFO access needs oscillator enabled and stable
package spi_frame_pkg;

    localparam int BYTE_W = 8;
    localparam int ADDR_W = 6;
    localparam int LEN_W = 7;

    localparam logic [1:0] MODE_REG_WRITE = 2'h0;
    localparam logic [1:0] MODE_REG_READ = 2'h1;
    localparam logic [1:0] MODE_FIFO = 2'h2;
    localparam logic [1:0] MODE_COMMAND = 2'h3;

    localparam logic [5:0] CODE_FIFO_LOAD = 6'h00;
    localparam logic [5:0] CODE_FIFO_READ = 6'h3F;

    localparam logic [6:0] FIFO_MAX_BYTES = 7'h60;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Core clock and serial timing, times in ns
    localparam int CLK_PERIOD_NS = 40;
    localparam int SCLK_HALF_NS = 50;
    localparam int SS_HIGH_NS = 100;
    localparam int SS_LEAD_NS = 25;
    localparam logic [2:0] SCLK_HALF_CYC =
        3'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] SS_HIGH_CYC =
        3'((SS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] SS_LEAD_CYC =
        3'((SS_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage : spi_frame_pkg

// *** core/spi_link_if.sv ***
// Four-wire serial link between the master and the frame decoder
`timescale 1ns/1ps
interface spi_link_if;
    logic ss_n;
    logic sclk;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic miso;

    // Line level with the pull-down taking over when undriven
    assign miso = miso_oe ? miso_o : 1'b0;

    modport dev (
        input ss_n,
        input sclk,
        input mosi,
        output miso_o,
        output miso_oe
    );

    modport host (
        output ss_n,
        output sclk,
        output mosi,
        input miso
    );
endinterface : spi_link_if

// *** core/spi_edge_detect.sv ***
// Rise and fall detector for a signal synchronous to the core clock
`timescale 1ns/1ps
module spi_edge_detect (
    input wire logic core_clk, // Core clock
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic sig, // Watched level
    output logic rise, // High in the cycle the level goes high
    output logic fall // High in the cycle the level goes low
);
    typedef struct packed {
        logic prev;
    } edge_reg_type;

    edge_reg_type q;
    edge_reg_type d;

    always_comb begin
        d = q;
        d.prev = sig;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rise = sig & ~q.prev;
    assign fall = ~sig & q.prev;
endmodule : spi_edge_detect

// *** core/spi_frame_device.sv ***
// Device end: decodes serial frames into register, FIFO and command actions
`timescale 1ns/1ps
module spi_frame_device
    import spi_frame_pkg::*;
(
    input wire logic core_clk, // Core clock
    input wire logic sys_rst, // Asynchronous reset, active high
    spi_link_if.dev link, // Serial pins
    output logic [spi_frame_pkg::ADDR_W-1:0] reg_addr, // Current address
    input wire logic [spi_frame_pkg::BYTE_W-1:0] reg_rd_data, // Reg value
    input wire logic reg_present, // Register exists at reg_addr
    input wire logic reg_writable, // Register at reg_addr is writable
    output logic reg_wr, // Write strobe, one cycle
    output logic [spi_frame_pkg::ADDR_W-1:0] reg_wr_addr, // Write address
    output logic [spi_frame_pkg::BYTE_W-1:0] reg_wr_data, // Write data
    input wire logic fifo_enable, // Oscillator enabled and stable
    output logic fifo_push, // FIFO load strobe, one cycle
    output logic [spi_frame_pkg::BYTE_W-1:0] fifo_push_data, // Load byte
    output logic fifo_over, // Load beyond FIFO size, one cycle
    input wire logic [spi_frame_pkg::BYTE_W-1:0] fifo_head, // Oldest byte
    output logic fifo_pop, // Head byte fully read, one cycle
    output logic cmd_launch, // Direct command strobe, one cycle
    output logic [spi_frame_pkg::ADDR_W-1:0] command_code_bits, // Command
    output logic operation_active, // Select low, frame in progress
    input wire logic proc_done, // Lasting process finished
    output logic irq // Interrupt output
);
    import spi_frame_pkg::*;

    typedef enum logic [2:0] {
        ST_MODE,
        ST_WRITE,
        ST_READ,
        ST_LOAD,
        ST_FREAD,
        ST_SKIP
    } dev_state_type;

    typedef struct packed {
        dev_state_type st;
        logic [2:0] bit_cnt;
        logic [7:0] rx_sh;
        logic [7:0] tx_byte;
        logic [5:0] addr;
        logic [6:0] load_cnt;
        logic miso;
        logic miso_oe;
        logic wr_stb;
        logic [5:0] wr_addr;
        logic [7:0] wr_data;
        logic push;
        logic over;
        logic [7:0] push_data;
        logic pop;
        logic cmd_stb;
        logic [5:0] cmd_code;
        logic active;
        logic irq;
    } dev_reg_type;

    dev_reg_type q;
    dev_reg_type d;

    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] byte_in;
    logic [7:0] src_byte;

    spi_edge_detect u_sclk_edge (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .sig(link.sclk),
        .rise(sclk_rise),
        .fall(sclk_fall)
    );

    // Byte as it stands once the current falling edge is shifted in
    assign byte_in = {q.rx_sh[6:0], link.mosi};

    // Source of the byte the next read slot will send
    always_comb begin
        src_byte = '0;
        if (q.st == ST_FREAD) begin
            src_byte = fifo_head;
        end else if (reg_present) begin
            src_byte = reg_rd_data;
        end else begin
            src_byte = '0;
        end
    end

    always_comb begin
        d = q;
        d.wr_stb = 1'b0;
        d.push = 1'b0;
        d.over = 1'b0;
        d.pop = 1'b0;
        d.cmd_stb = 1'b0;
        d.active = ~link.ss_n;
        // Completion is signalled by the process itself, so follow it
        d.irq = proc_done;
        if (link.ss_n) begin
            // Any partly shifted byte dies here, so nothing is written
            d.st = ST_MODE;
            d.bit_cnt = '0;
            d.miso = 1'b0;
            d.miso_oe = 1'b0;
            d.load_cnt = '0;
        end else begin
            if (sclk_fall) begin
                d.rx_sh = byte_in;
                d.bit_cnt = q.bit_cnt + 3'h1;
                if (q.bit_cnt == BIT_LAST) begin
                    case (q.st)
                        ST_MODE: begin
                            case (byte_in[7:6])
                                MODE_REG_WRITE: begin
                                    d.st = ST_WRITE;
                                    d.addr = byte_in[5:0];
                                end
                                MODE_REG_READ: begin
                                    d.st = ST_READ;
                                    d.addr = byte_in[5:0];
                                end
                                MODE_FIFO: begin
                                    if (!fifo_enable) begin
                                        d.st = ST_SKIP;
                                    end else if (byte_in[5:0] ==
                                                 CODE_FIFO_LOAD) begin
                                        d.st = ST_LOAD;
                                    end else if (byte_in[5:0] ==
                                                 CODE_FIFO_READ) begin
                                        d.st = ST_FREAD;
                                    end else begin
                                        d.st = ST_SKIP;
                                    end
                                end
                                default: begin
                                    // Stay in mode decode to allow chaining
                                    d.cmd_stb = 1'b1;
                                    d.cmd_code = byte_in[5:0];
                                    d.st = ST_MODE;
                                end
                            endcase
                        end
                        ST_WRITE: begin
                            if (reg_present && reg_writable) begin
                                d.wr_stb = 1'b1;
                                d.wr_addr = q.addr;
                                d.wr_data = byte_in;
                            end
                            d.addr = q.addr + 6'h01;
                        end
                        ST_READ: begin
                            d.addr = q.addr + 6'h01;
                        end
                        ST_LOAD: begin
                            // Excess bytes flagged rather than pushed
                            if (q.load_cnt == FIFO_MAX_BYTES) begin
                                d.over = 1'b1;
                            end else begin
                                d.push = 1'b1;
                                d.push_data = byte_in;
                                d.load_cnt = q.load_cnt + 7'h01;
                            end
                        end
                        ST_FREAD: begin
                            // Pop only once all eight bits have left
                            d.pop = 1'b1;
                        end
                        default: begin
                            d.st = q.st;
                        end
                    endcase
                end
            end
            if (sclk_rise && (q.st == ST_READ || q.st == ST_FREAD)) begin
                d.miso_oe = 1'b1;
                if (q.bit_cnt == '0) begin
                    // Latch the whole byte so it cannot change mid-shift
                    d.tx_byte = src_byte;
                    d.miso = src_byte[7];
                end else begin
                    d.miso = q.tx_byte[3'(BIT_LAST - q.bit_cnt)];
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign link.miso_o = q.miso;
    assign link.miso_oe = q.miso_oe;
    assign reg_addr = q.addr;
    assign reg_wr = q.wr_stb;
    assign reg_wr_addr = q.wr_addr;
    assign reg_wr_data = q.wr_data;
    assign fifo_push = q.push;
    assign fifo_push_data = q.push_data;
    assign fifo_over = q.over;
    assign fifo_pop = q.pop;
    assign cmd_launch = q.cmd_stb;
    assign command_code_bits = q.cmd_code;
    assign operation_active = q.active;
    assign irq = q.irq;
endmodule : spi_frame_device

// *** core/spi_frame_host.sv ***
// Master end: builds select, clock and data frames from user requests
`timescale 1ns/1ps
module spi_frame_host
    import spi_frame_pkg::*;
(
    input wire logic core_clk, // Core clock
    input wire logic sys_rst, // Asynchronous reset, active high
    spi_link_if.host link, // Serial pins
    input wire logic req_valid, // Frame request
    output logic req_ready, // Request taken when both high
    input wire logic [spi_frame_pkg::BYTE_W-1:0] req_header, // First byte
    input wire logic [spi_frame_pkg::LEN_W-1:0] req_len, // Data bytes
    input wire logic req_hold, // Keep select low afterwards
    input wire logic chain_end, // Release a held select
    input wire logic [spi_frame_pkg::BYTE_W-1:0] tx_data, // Next write byte
    output logic tx_take, // tx_data consumed, one cycle
    output logic [spi_frame_pkg::BYTE_W-1:0] rx_data, // Received byte
    output logic rx_valid, // rx_data new, one cycle
    output logic busy // Frame in progress
);
    import spi_frame_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE,
        H_LEAD,
        H_HIGH,
        H_LOW,
        H_CHAIN,
        H_GAP
    } host_state_type;

    typedef struct packed {
        host_state_type st;
        logic [2:0] cnt;
        logic [2:0] bit_cnt;
        logic [7:0] tx_sh;
        logic [7:0] rx_sh;
        logic [6:0] left;
        logic is_read;
        logic hdr_done;
        logic hold;
        logic sclk;
        logic ss_n;
        logic mosi;
        logic [7:0] rx_data;
        logic rx_valid;
        logic tx_take;
    } host_reg_type;

    host_reg_type q;
    host_reg_type d;
    logic [7:0] next_byte;

    // Header whose data bytes flow from device to master
    function automatic logic reads_back(input logic [7:0] hdr);
        reads_back = (hdr[7:6] == MODE_REG_READ) ||
                     (hdr == {MODE_FIFO, CODE_FIFO_READ});
    endfunction : reads_back

    assign req_ready = (q.st == H_IDLE) || (q.st == H_CHAIN);
    assign next_byte = (q.bit_cnt != '0) ? q.tx_sh :
                       (q.is_read ? 8'h00 : tx_data);

    always_comb begin
        d = q;
        d.rx_valid = 1'b0;
        d.tx_take = 1'b0;
        d.cnt = q.cnt + 3'h1;
        case (q.st)
            H_IDLE, H_CHAIN: begin
                d.cnt = '0;
                if (req_valid) begin
                    d.st = H_LEAD;
                    d.ss_n = 1'b0;
                    d.tx_sh = req_header;
                    d.left = req_len;
                    d.is_read = reads_back(req_header);
                    d.hdr_done = 1'b0;
                    d.hold = req_hold;
                    d.bit_cnt = '0;
                end else if (q.st == H_CHAIN && chain_end) begin
                    d.st = H_GAP;
                    d.ss_n = 1'b1;
                end
            end
            H_LEAD: begin
                if (q.cnt == SS_LEAD_CYC - 3'h1) begin
                    d.st = H_HIGH;
                    d.cnt = '0;
                    d.sclk = 1'b1;
                    d.mosi = q.tx_sh[7];
                end
            end
            H_HIGH: begin
                if (q.cnt == SCLK_HALF_CYC - 3'h1) begin
                    d.st = H_LOW;
                    d.cnt = '0;
                    d.sclk = 1'b0;
                    d.rx_sh = {q.rx_sh[6:0], link.miso};
                    d.tx_sh = {q.tx_sh[6:0], 1'b0};
                    d.bit_cnt = q.bit_cnt + 3'h1;
                    if (q.bit_cnt == BIT_LAST) begin
                        d.hdr_done = 1'b1;
                        if (q.hdr_done && q.is_read) begin
                            d.rx_data = {q.rx_sh[6:0], link.miso};
                            d.rx_valid = 1'b1;
                        end
                    end
                end
            end
            H_LOW: begin
                if (q.cnt == SCLK_HALF_CYC - 3'h1) begin
                    d.cnt = '0;
                    if (q.bit_cnt == '0 && q.left == '0) begin
                        // Whole bytes only, never a cut byte
                        d.st = q.hold ? H_CHAIN : H_GAP;
                        d.ss_n = ~q.hold;
                    end else begin
                        if (q.bit_cnt == '0) begin
                            d.left = q.left - 7'h01;
                            d.tx_take = ~q.is_read;
                        end
                        d.tx_sh = next_byte;
                        d.mosi = next_byte[7];
                        d.sclk = 1'b1;
                        d.st = H_HIGH;
                    end
                end
            end
            H_GAP: begin
                if (q.cnt == SS_HIGH_CYC - 3'h1) begin
                    d.st = H_IDLE;
                    d.cnt = '0;
                end
            end
            default: begin
                d.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '{st: H_IDLE, ss_n: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    assign link.ss_n = q.ss_n;
    assign link.sclk = q.sclk;
    assign link.mosi = q.mosi;
    assign tx_take = q.tx_take;
    assign rx_data = q.rx_data;
    assign rx_valid = q.rx_valid;
    assign busy = (q.st != H_IDLE);
endmodule : spi_frame_host

// *** sim/spi_link_checker.sv ***
// Wire-level checks on the serial link between master and device
`timescale 1ns/1ps
module spi_link_checker (
    input wire logic core_clk, // Core clock
    input wire logic sys_rst, // Reset, active high
    input wire logic ss_n, // Select, active low
    input wire logic sclk, // Serial clock
    input wire logic mosi, // Master data
    input wire logic miso_o, // Device data
    input wire logic miso_oe, // Device drive enable
    input wire logic miso // Resolved line
);
    logic [11:0] falls_q;
    logic sclk_q;

    // Falls since select went low, to tell header bits from data bits
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            falls_q <= 12'h000;
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
            if (ss_n) begin
                falls_q <= 12'h000;
            end else if (sclk_q && !sclk) begin
                falls_q <= falls_q + 12'h001;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence high_half_s;
        sclk [*2] ##1 !sclk;
    endsequence
    sequence low_half_s;
        !sclk [*2];
    endsequence
    sequence gap_s;
        ss_n [*3];
    endsequence

    a_sclk_idle: assert property (ss_n |-> !sclk)
        else $error("serial clock high while deselected");
    a_high_half: assert property ($rose(sclk) |-> high_half_s)
        else $error("serial clock high half wrong");
    a_low_half: assert property ($fell(sclk) |-> low_half_s)
        else $error("serial clock low half too short");
    a_select_gap: assert property ($rose(ss_n) |-> gap_s)
        else $error("select high gap too short");
    a_mosi_hold: assert property (
        sclk && $past(sclk) |-> $stable(mosi))
        else $error("master data moved while clock high");
    a_miso_on_rise: assert property (
        miso_oe && $past(miso_oe) && $changed(miso_o) |-> $past(sclk))
        else $error("device data moved away from a rising edge");
    a_oe_released: assert property (
        ss_n && $past(ss_n) && $past(ss_n, 2) |-> !miso_oe)
        else $error("device drives line while deselected");
    a_oe_after_header: assert property (
        $rose(miso_oe) |-> falls_q >= 12'h008)
        else $error("device drives line before header done");
    a_whole_bytes: assert property (
        $rose(ss_n) |-> falls_q[2:0] == 3'h0)
        else $error("frame ended inside a byte");
endmodule : spi_link_checker

// *** sim/testbench.sv ***
// Bench: host and device joined, plus a second device driven by hand
`timescale 1ns/1ps
module testbench;
    import spi_frame_pkg::*;
    typedef struct packed {
        logic [7:0] hdr;
        logic [6:0] len;
        logic [7:0] d0;
        logic [7:0] d1;
        logic [7:0] e0;
        logic [7:0] e1;
    } row_type;
    localparam int ROWS = 9;
    localparam int LIMIT = 20000;
    localparam row_type ROW_TAB [ROWS] = '{
        '{8'h05, 7'h02, 8'h3C, 8'hC3, 8'h00, 8'h00},
        '{8'h28, 7'h01, 8'h77, 8'h00, 8'h00, 8'h00},
        '{8'h45, 7'h02, 8'h00, 8'h00, 8'h3C, 8'hC3},
        '{8'h67, 7'h02, 8'h00, 8'h00, 8'h37, 8'h38},
        '{8'h70, 7'h02, 8'h00, 8'h00, 8'h00, 8'h00},
        '{8'h80, 7'h02, 8'h11, 8'h22, 8'h00, 8'h00},
        '{8'h81, 7'h01, 8'h99, 8'h00, 8'h00, 8'h00},
        '{8'hBF, 7'h02, 8'h00, 8'h00, 8'h11, 8'h22},
        '{8'hC5, 7'h00, 8'h00, 8'h00, 8'h05, 8'h00}};
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    int bad_count = 0;
    int checks_done = 0;
    logic [7:0] regs [64];
    logic [7:0] fmem [128];
    int wp = 0;
    int rp = 0;
    int overs = 0;
    logic [5:0] last_cmd = 6'h00;
    logic [7:0] tx_buf [128];
    int tx_idx = 0;
    logic [7:0] rx_buf [8];
    int rx_n = 0;
    logic [7:0] got;
    logic req_valid = 1'b0;
    logic req_ready;
    logic [7:0] req_header = 8'h00;
    logic [6:0] req_len = 7'h00;
    logic req_hold = 1'b0;
    logic tx_take;
    logic [7:0] rx_data;
    logic rx_valid;
    logic busy;
    logic chain_end = 1'b0;
    logic fifo_en = 1'b1;
    logic proc_done = 1'b0;
    logic [7:0] fhead;
    logic [5:0] ra [2];
    logic [7:0] rd [2];
    logic wr [2];
    logic [5:0] wa [2];
    logic [7:0] wd [2];
    logic push [2];
    logic [7:0] pd [2];
    logic over [2];
    logic pop [2];
    logic cmd [2];
    logic [5:0] code [2];
    logic irq [2];
    logic act [2];

    spi_link_if lk [2] ();
    assign fhead = fmem[7'(rp)];

    // Absent places hold nonzero values so a zero read means refusal
    for (genvar g = 0; g < 2; g++) begin : dev
        assign rd[g] = regs[ra[g]];
        spi_frame_device spi_frame_device_i (.core_clk(core_clk),
            .sys_rst(sys_rst), .link(lk[g]), .reg_addr(ra[g]),
            .reg_rd_data(rd[g]), .reg_present(ra[g] < 6'h30),
            .reg_writable(ra[g] < 6'h28), .reg_wr(wr[g]),
            .reg_wr_addr(wa[g]), .reg_wr_data(wd[g]),
            .fifo_enable(fifo_en), .fifo_push(push[g]),
            .fifo_push_data(pd[g]), .fifo_over(over[g]),
            .fifo_head(fhead), .fifo_pop(pop[g]), .cmd_launch(cmd[g]),
            .command_code_bits(code[g]), .operation_active(act[g]),
            .proc_done(proc_done), .irq(irq[g]));
    end
    spi_frame_host spi_frame_host_i (.core_clk(core_clk),
        .sys_rst(sys_rst), .link(lk[0]), .req_valid(req_valid),
        .req_ready(req_ready), .req_header(req_header), .req_len(req_len),
        .req_hold(req_hold), .chain_end(chain_end),
        .tx_data(tx_buf[7'(tx_idx)]),
        .tx_take(tx_take), .rx_data(rx_data), .rx_valid(rx_valid),
        .busy(busy));
    spi_link_checker spi_link_checker_i (.core_clk(core_clk),
        .sys_rst(sys_rst), .ss_n(lk[0].ss_n), .sclk(lk[0].sclk),
        .mosi(lk[0].mosi), .miso_o(lk[0].miso_o),
        .miso_oe(lk[0].miso_oe), .miso(lk[0].miso));

    // Register file and FIFO shared by both device ends
    always @(posedge core_clk) begin
        for (int g = 0; g < 2; g++) begin
            if (wr[g] === 1'b1) regs[wa[g]] <= wd[g];
            if (push[g] === 1'b1) fmem[7'(wp)] <= pd[g];
            if (push[g] === 1'b1) wp <= wp + 1;
            if (pop[g] === 1'b1) rp <= rp + 1;
            if (over[g] === 1'b1) overs <= overs + 1;
            if (cmd[g] === 1'b1) last_cmd <= code[g];
        end
        if (tx_take === 1'b1) tx_idx <= tx_idx + 1;
        if (rx_valid === 1'b1) rx_buf[3'(rx_n)] <= rx_data;
        if (rx_valid === 1'b1) rx_n <= rx_n + 1;
    end

    task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : check_byte

    task automatic check_bit(input logic g, input logic e);
        check_byte({7'h00, g}, {7'h00, e});
    endtask : check_bit

    task automatic finish_test();
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    task automatic frame(input logic [7:0] h, input logic [6:0] n,
            input logic hold);
        @(negedge core_clk);
        tx_idx = 0;
        rx_n = 0;
        req_header = h;
        req_len = n;
        req_hold = hold;
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(negedge core_clk);
        @(negedge core_clk);
        req_valid = 1'b0;
        check_bit(busy, 1'b1);
        while (req_ready !== 1'b1) @(negedge core_clk);
    endtask : frame

    // Hand-driven master on the second link, n bits MSB first
    task automatic bb(input logic [7:0] v, input int n);
        got = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            lk[1].mosi = v[i];
            lk[1].sclk = 1'b1;
            repeat (2) @(negedge core_clk);
            got[i] = lk[1].miso;
            lk[1].sclk = 1'b0;
            repeat (2) @(negedge core_clk);
        end
    endtask : bb

    task automatic bb_sel(input logic low);
        repeat (2) @(negedge core_clk);
        lk[1].ss_n = !low;
        // Released data line flips so a stale level is never trusted
        if (!low) lk[1].mosi = !lk[1].mosi;
        repeat (4) @(negedge core_clk);
    endtask : bb_sel

    initial begin
        forever #(CLK_PERIOD_NS / 2) core_clk = !core_clk;
    end

    initial begin
        repeat (LIMIT) @(posedge core_clk);
        bad_count++;
        finish_test();
    end

    initial begin
        lk[1].ss_n = 1'b1;
        lk[1].sclk = 1'b0;
        lk[1].mosi = 1'b0;
        for (int i = 0; i < 64; i++) regs[i] = 8'(i) + 8'h10;
        repeat (8) @(negedge core_clk);
        check_bit(lk[0].ss_n, 1'b1);
        check_bit(lk[0].miso_oe, 1'b0);
        check_bit(req_ready, 1'b1);
        check_bit(busy, 1'b0);
        sys_rst = 1'b0;
        for (int i = 0; i < ROWS; i++) begin
            tx_buf[0] = ROW_TAB[i].d0;
            tx_buf[1] = ROW_TAB[i].d1;
            frame(ROW_TAB[i].hdr, ROW_TAB[i].len, 1'b0);
            if (ROW_TAB[i].hdr[7:6] == MODE_COMMAND) begin
                check_byte({2'h0, last_cmd}, ROW_TAB[i].e0);
            end else if (ROW_TAB[i].hdr[7:6] == MODE_REG_READ ||
                    ROW_TAB[i].hdr == 8'hBF) begin
                check_byte(8'(rx_n), 8'h02);
                check_byte(rx_buf[0], ROW_TAB[i].e0);
                check_byte(rx_buf[1], ROW_TAB[i].e1);
            end
        end
        check_byte(8'(wp - rp), 8'h00);
        frame(8'hC1, 7'h00, 1'b1);
        frame(8'h45, 7'h01, 1'b0);
        check_byte({2'h0, last_cmd}, 8'h01);
        check_byte(rx_buf[0], 8'h3C);
        frame(8'hC2, 7'h00, 1'b1);
        chain_end = 1'b1;
        @(negedge core_clk);
        chain_end = 1'b0;
        check_bit(lk[0].ss_n, 1'b1);
        check_byte({2'h0, last_cmd}, 8'h02);
        fifo_en = 1'b0;
        tx_buf[0] = 8'h44;
        frame(8'h80, 7'h01, 1'b0);
        frame(8'hBF, 7'h01, 1'b0);
        check_byte(8'(wp - rp), 8'h00);
        check_byte(rx_buf[0], 8'h00);
        fifo_en = 1'b1;
        for (int i = 0; i < 128; i++) tx_buf[i] = 8'(i);
        frame(8'h80, 7'h61, 1'b0);
        check_byte(8'(wp - rp), {1'b0, FIFO_MAX_BYTES});
        check_byte(fmem[7'(wp - 1)], 8'h5F);
        check_byte(8'(overs), 8'h01);
        rp = wp;
        proc_done = 1'b1;
        repeat (2) @(negedge core_clk);
        check_bit(irq[0], 1'b1);
        check_bit(irq[1], 1'b1);
        proc_done = 1'b0;
        bb_sel(1'b1);
        check_bit(act[1], 1'b1);
        check_bit(irq[0], 1'b0);
        bb(8'h06, 8);
        bb(8'hFF, 5);
        bb_sel(1'b0);
        check_byte(regs[6], 8'hC3);
        check_bit(act[1], 1'b0);
        bb_sel(1'b1);
        bb(8'h80, 8);
        bb(8'h5A, 8);
        bb(8'hFF, 4);
        bb_sel(1'b0);
        check_byte(8'(wp - rp), 8'h01);
        check_byte(fhead, 8'h5A);
        bb_sel(1'b1);
        bb(8'hBF, 8);
        bb(8'h00, 4);
        bb_sel(1'b0);
        check_bit(lk[1].miso_oe, 1'b0);
        check_byte(8'(wp - rp), 8'h01);
        bb_sel(1'b1);
        bb(8'hBF, 8);
        bb(8'h00, 8);
        bb_sel(1'b0);
        check_byte(got, 8'h5A);
        check_byte(8'(wp - rp), 8'h00);
        finish_test();
    end
endmodule : testbench
